// [design/stdc_pkg.sv]
package stdc_pkg;

  // ****************************************************************
  // Counter geometry and reset values
  // ****************************************************************
  localparam int STDC_CNT_W = 24;
  localparam logic [23:0] STDC_CNT_ZERO = 24'h000000;
  localparam logic [23:0] STDC_CNT_ONE = 24'h000001;
  localparam logic [23:0] STDC_RST_VAL = 24'h000000;
  localparam logic [2:0] STDC_SYNC_RST = 3'h0;

endpackage : stdc_pkg

// [design/stdc_sync3.sv]
`timescale 1ns/10ps
module stdc_sync3
  import stdc_pkg::*;
(
  input wire logic clk_i,   // Core clock.
  input wire logic rst_b_i, // Asynchronous reset, active low.
  input wire logic d_i,     // Asynchronous level.
  output logic q_o          // Filtered level.
);

  logic [2:0] sh_r;
  logic [2:0] sh_nxt;
  logic q_r;
  logic q_nxt;

  // Stage 0 feeds only stage 1; a change counts once 1 and 2 agree.
  always_comb begin
    sh_nxt = {sh_r[1:0], d_i};
    q_nxt = (sh_r[1] == sh_r[2]) ? sh_r[2] : q_r;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sh_r <= STDC_SYNC_RST;
      q_r <= 1'b0;
    end else begin
      sh_r <= sh_nxt;
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;

endmodule // stdc_sync3

// [design/stdc_timer.sv]
`timescale 1ns/10ps
// Summary of operation
// - 24-bit counter decrements once per clock.
// - At zero, reload next edge, continue.
// - Debug halt holds count, no decrement.
// - Runs on core clock; gated clock stops it.
// - Reload and count need no reset value.
module stdc_timer
  import stdc_pkg::*;
(
  input wire logic clk_i,              // Core clock, gated in low power.
  input wire logic rst_b_i,            // Core reset, active low.
  input wire logic enable_i,           // Counting enabled.
  input wire logic debug_halt_i,       // Core halted for debug (pin level).
  input wire logic reload_wr_i,        // Write strobe, reload register.
  input wire logic [23:0] reload_wdata_i, // Reload data.
  input wire logic count_wr_i,         // Write strobe, current count.
  output logic [23:0] reload_o,        // Reload register contents.
  output logic [23:0] count_o,         // Current count.
  output logic wrap_o                  // Pulse: count reached zero.
);

  // ****************************************************************
  // Debug halt input
  // ****************************************************************
  logic halt_s;

  stdc_sync3 u_halt_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .d_i(debug_halt_i),
    .q_o(halt_s)
  );

  // The filter adds four edges of delay; a halt request shorter than
  // two samples is dropped, which is harmless for a debug stop.
  a_halt_rise: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(halt_s) |-> $past(debug_halt_i, 3) && $past(debug_halt_i, 4))
    else $error("halt seen without two agreeing samples");

  a_halt_fall: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $fell(halt_s) |-> !$past(debug_halt_i, 3) && !$past(debug_halt_i, 4))
    else $error("halt released without two agreeing samples");

  // ****************************************************************
  // Reload register
  // ****************************************************************
  // allows no reset here; a constant reset is kept anyway so that
  // simulation never carries X into the count or the wrap pulse.
  logic [23:0] tick_reload_value_register_r;
  logic [23:0] tick_reload_value_register_nxt;

  // Only whole words arrive, so there is no byte lane to merge. A write
  // and a reload in one cycle do not race: the counter takes the value
  // held before the write, and the new one serves the next period.
  always_comb begin
    tick_reload_value_register_nxt = tick_reload_value_register_r;
    if (reload_wr_i) begin
      tick_reload_value_register_nxt = reload_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_reload_value_register_r <= STDC_RST_VAL;
    end else begin
      tick_reload_value_register_r <= tick_reload_value_register_nxt;
    end
  end

  assign reload_o = tick_reload_value_register_r;

  a_reload_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !reload_wr_i |=> $stable(tick_reload_value_register_r))
    else $error("reload value changed without a write");

  a_reload_kept: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (count_wr_i && !reload_wr_i)
    |=> $stable(tick_reload_value_register_r))
    else $error("count write disturbed the reload value");

  // ****************************************************************
  // Down counter
  // ****************************************************************
  logic [23:0] cnt_r;
  logic [23:0] cnt_nxt;
  logic step_ok;

  // A count write beats halt and enable, so software can restart the
  // period while the core is stopped.
  assign step_ok = enable_i && !halt_s && !count_wr_i;

  always_comb begin
    cnt_nxt = cnt_r;
    if (count_wr_i) begin
      cnt_nxt = STDC_CNT_ZERO;
    end else if (step_ok) begin
      if (cnt_r == STDC_CNT_ZERO) begin
        cnt_nxt = tick_reload_value_register_r;
      end else begin
        cnt_nxt = cnt_r - STDC_CNT_ONE;
      end
    end
  end

  // Every register here runs on clk_i alone; when the core clock is
  // gated for low power the whole timer freezes with it.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= STDC_RST_VAL;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign count_o = cnt_r;

  a_step_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!step_ok && !count_wr_i) |=> $stable(cnt_r))
    else $error("count moved without a step or a write");

  a_reload_no_jolt: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (reload_wr_i && step_ok && cnt_r != STDC_CNT_ZERO)
    |=> cnt_r == $past(cnt_r) - STDC_CNT_ONE)
    else $error("reload write disturbed the running count");

  a_reload_old_val: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (reload_wr_i && step_ok && cnt_r == STDC_CNT_ZERO)
    |=> cnt_r == $past(tick_reload_value_register_r))
    else $error("reload at zero did not use the held value");

  // ****************************************************************
  // Wrap pulse
  // ****************************************************************
  logic wrap_r;
  logic wrap_nxt;

  // Raised only on the step from one to zero; a clear by a count write
  // is no finished period and raises nothing.
  always_comb begin
    wrap_nxt = 1'b0;
    if (step_ok && cnt_r == STDC_CNT_ONE) begin
      wrap_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wrap_r <= 1'b0;
    end else begin
      wrap_r <= wrap_nxt;
    end
  end

  assign wrap_o = wrap_r;

  // The pulse marks one finished period; it never spans two cycles.
  a_wrap_single: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wrap_r |=> !wrap_r)
    else $error("wrap pulse longer than one cycle");

  a_wrap_cause: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (step_ok && cnt_r == STDC_CNT_ONE) |=> wrap_r)
    else $error("step from one to zero gave no wrap pulse");

  a_wrap_reload: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (wrap_r && step_ok) |=> cnt_r == $past(tick_reload_value_register_r))
    else $error("no reload on the edge after the wrap");

  a_clear_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    count_wr_i |=> !wrap_r)
    else $error("count write raised a wrap pulse");

  a_halt_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    halt_s |=> !wrap_r)
    else $error("wrap pulse while halted");

  a_idle_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !enable_i |=> !wrap_r)
    else $error("wrap pulse while disabled");

  a_mid_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (step_ok && cnt_r > STDC_CNT_ONE) |=> !wrap_r)
    else $error("wrap pulse before the count reached zero");

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_count_dec: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (enable_i && !halt_s && !count_wr_i && cnt_r != STDC_CNT_ZERO)
    |=> cnt_r == $past(cnt_r) - STDC_CNT_ONE)
    else $error("count did not decrement by one");

  a_zero_reload: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (enable_i && !halt_s && !count_wr_i && cnt_r == STDC_CNT_ZERO)
    |=> cnt_r == $past(tick_reload_value_register_r))
    else $error("count did not reload at zero");

  a_halt_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (halt_s && !count_wr_i) |=> $stable(cnt_r))
    else $error("count moved during debug halt");

  a_idle_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!enable_i && !count_wr_i) |=> $stable(cnt_r))
    else $error("count moved while disabled");

  a_clear_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    count_wr_i |=> cnt_r == STDC_CNT_ZERO)
    else $error("count write did not clear");

  a_wrap_pulse: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wrap_r |-> cnt_r == STDC_CNT_ZERO && $past(cnt_r) == STDC_CNT_ONE)
    else $error("wrap pulse without reaching zero");

  a_reload_store: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    reload_wr_i |=> tick_reload_value_register_r == $past(reload_wdata_i))
    else $error("reload value not stored");

  a_halt_stretch: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (halt_s && !count_wr_i)[*2] |=> cnt_r == $past(cnt_r, 2))
    else $error("count drifted over halted cycles");

endmodule // stdc_timer

// [testbench/stdc_timer_tb_top.sv]
`timescale 1ns/10ps
module stdc_timer_tb_top
  import stdc_pkg::*;
;
  // ****************************************************************
  // Stimulus, design and clock
  // ****************************************************************
  logic clk_i = 1'b0;
  logic gate = 1'b0;
  logic rst_b_i = 1'b0;
  logic enable_i = 1'b0;
  logic debug_halt_i = 1'b0;
  logic reload_wr_i = 1'b0;
  logic [23:0] reload_wdata_i = 24'h000000;
  logic count_wr_i = 1'b0;
  logic [23:0] reload_o;
  logic [23:0] count_o;
  logic [23:0] held;
  logic wrap_o;
  int n_mismatch = 0;
  int tests_run = 0;
  // Gating freezes the clock level, as a low-power clock stop would.
  always #2.5 if (!gate) clk_i = ~clk_i;
  stdc_timer uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .enable_i(enable_i),
    .debug_halt_i(debug_halt_i), .reload_wr_i(reload_wr_i),
    .reload_wdata_i(reload_wdata_i), .count_wr_i(count_wr_i),
    .reload_o(reload_o), .count_o(count_o), .wrap_o(wrap_o));
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic count_walk;
    @(posedge clk_i);
    reload_wr_i <= 1'b1;
    reload_wdata_i <= 24'h000003;
    @(posedge clk_i);
    reload_wr_i <= 1'b0;
    count_wr_i <= 1'b1;
    @(posedge clk_i);
    count_wr_i <= 1'b0;
    enable_i <= 1'b1;
    #1 chk(count_o, STDC_CNT_ZERO);
    for (int i = 0; i <= 4; i++) begin
      @(posedge clk_i);
      #1 chk(count_o, (i == 4) ? 24'h000003 : 24'h000003 - 24'(i));
      chk({23'h000000, wrap_o}, {23'h000000, i == 3});
    end
  endtask
  task automatic hold_in_halt;
    @(posedge clk_i);
    debug_halt_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1 held = count_o;
    repeat (3) @(posedge clk_i);
    debug_halt_i <= 1'b0;
    #1 chk(count_o, held);
    repeat (5) @(posedge clk_i);
    #1 chk(count_o, STDC_CNT_ONE);
  endtask
  task automatic gated_clock;
    @(posedge clk_i);
    #1 held = count_o;
    gate = 1'b1;
    #50 chk(count_o, held);
    gate = 1'b0;
    @(posedge clk_i);
    #1 chk(count_o, 24'h000003);
  endtask
  task automatic clear_mid_count;
    @(posedge clk_i);
    count_wr_i <= 1'b1;
    @(posedge clk_i);
    count_wr_i <= 1'b0;
    #1 chk(count_o, STDC_CNT_ZERO);
    chk(reload_o, 24'h000003);
    @(posedge clk_i);
    #1 chk(count_o, 24'h000003);
  endtask
  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    count_walk();
    hold_in_halt();
    gated_clock();
    clear_mid_count();
    complete_run();
  end
  initial begin
    #20000;
    n_mismatch++;
    complete_run();
  end
endmodule // stdc_timer_tb_top
